// *** common/tsm_map.vh ***
// Register map, field positions, state diagnostics and timing for the sensor monitor
`ifndef TSM_MAP_VH
`define TSM_MAP_VH

// APB byte offsets
`define TSM_CTRL_OFF 12'h000
`define TSM_STAT_OFF 12'h004
`define TSM_DIAG_OFF 12'h008
`define TSM_WIN_OFF 12'h00C

// Control register fields
`define TSM_CTRL_ENABLE 0
`define TSM_CTRL_BEGIN 1
`define TSM_CTRL_SKIP_MAN 2
`define TSM_CTRL_PWR_REARM 3
`define TSM_CTRL_AUTO_REARM 4
`define TSM_CTRL_REARM 5
`define TSM_CTRL_W 6
`define TSM_CTRL_RST 6'h00

// Status register fields
`define TSM_STAT_READY 0
`define TSM_STAT_SAFE 1
`define TSM_STAT_ALLOWED 2
`define TSM_STAT_PASSED 3
`define TSM_STAT_DEMAND 4
`define TSM_STAT_REARM_REQ 5
`define TSM_STAT_ERROR 6
`define TSM_STAT_PROBE 7
`define TSM_STAT_MAN_PEND 8

// Diagnostic words
`define TSM_DG_IDLE 16'h0000
`define TSM_DG_RUN 16'h8000
`define TSM_DG_INHIBIT 16'h8001
`define TSM_DG_DEMAND 16'h8002
`define TSM_DG_PROBE_LOW 16'h8010
`define TSM_DG_PROBE_HIGH 16'h8011
`define TSM_DG_ERR_FALL 16'hC001
`define TSM_DG_ERR_RISE 16'hC002
`define TSM_DG_ERR_WINDOW 16'hC003

// Timing
`define TSM_CLK_MHZ 125
`define TSM_WINDOW_MS 10
`define TSM_WINDOW_MAX_MS 150
`define TSM_CNT_W 25

`endif

// *** design/tsm_sensor_monitor.v ***
// Testable light sensor monitor with register-requested self test and APB registers
`include "tsm_map.vh"

// What this block does
// R1: Test request drives probe low and starts the response timer.
// R2: Check window is a constant, default 10 ms, allowed 0 to 150 ms.
// R3: Probe output drives sensor test input and is high after reset.
// R4: Probe low means test requested; probe high means no test.
// R5: Sensor output is low under test or demand, high only when normal.
// R6: Safe output high only without protect demand and without error; low at reset.
// R7: Without skip option, a failed test blocks retest until manual switching sequence.
// R8: With skip option, retest is allowed right after a failed test.
// R9: Check-allowed output high when an automatic test can run; low at reset.
// R10: Check-passed rises on success; low before, during and after failed test.
// R11: Safe output stays high through the whole probe sequence.
// R12: Any error forces safe output low until a valid rearm clears it; a window misconfiguration error is not cleared by rearm.
// R13: Disable returns to idle from any state with top priority.
// R14: Without auto rearm, a rising rearm edge clears error or startup inhibit.
// R15: Window counted in clock cycles; unfinished response on expiry is an error.
// R16: Diagnostic word zero and all indications low after reset.
module tsm_sensor_monitor #(
  parameter CHECK_WINDOW_MS = `TSM_WINDOW_MS,
  parameter CHECK_WINDOW_CYCLES = (CHECK_WINDOW_MS * `TSM_CLK_MHZ * 1000 > 0) ?
                                  CHECK_WINDOW_MS * `TSM_CLK_MHZ * 1000 : 1
) (
  input wire I_REF_CLK,
  input wire I_RESET_N,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire I_SENSOR_SWITCH_IN,
  output wire O_PROBE_DRIVE,
  output wire O_SAFE_SWITCH_OUT,
  output wire O_CHECK_ALLOWED,
  output wire O_CHECK_PASSED,
  output wire O_ERROR
);

  // One-hot states
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_INHIBIT = 8'h02;
  localparam [7:0] ST_RUN = 8'h04;
  localparam [7:0] ST_DEMAND = 8'h08;
  localparam [7:0] ST_PROBE_LOW = 8'h10;
  localparam [7:0] ST_PROBE_HIGH = 8'h20;
  localparam [7:0] ST_ERROR = 8'h40;

  localparam [`TSM_CNT_W-1:0] WIN_CYC = CHECK_WINDOW_CYCLES[`TSM_CNT_W-1:0]; // R15
  localparam WIN_BAD = (CHECK_WINDOW_MS > `TSM_WINDOW_MAX_MS) ? 1'b1 : 1'b0; // R2

  reg [1:0] rst_sync_q;
  wire rst_n;
  reg [`TSM_CTRL_W-1:0] ctrl_q;
  reg [7:0] state_q;
  reg [7:0] state_d;
  reg [`TSM_CNT_W-1:0] cnt_q;
  reg [15:0] diag_q;
  reg [15:0] diag_d;
  reg passed_q;
  reg man_pend_q;
  reg man_seen_low_q;
  reg begin_prev_q;
  reg rearm_prev_q;
  reg sensor_prev_q;
  reg [31:0] rdata_q;

  wire enable = ctrl_q[`TSM_CTRL_ENABLE];
  wire skip_manual_recovery = ctrl_q[`TSM_CTRL_SKIP_MAN];
  wire power_up_rearm = ctrl_q[`TSM_CTRL_PWR_REARM];
  wire auto_rearm = ctrl_q[`TSM_CTRL_AUTO_REARM];
  wire begin_edge = ctrl_q[`TSM_CTRL_BEGIN] & ~begin_prev_q;
  wire rearm_edge = ctrl_q[`TSM_CTRL_REARM] & ~rearm_prev_q;
  wire sensor_rise = I_SENSOR_SWITCH_IN & ~sensor_prev_q;
  wire timeout = (cnt_q >= WIN_CYC);
  wire check_allowed = (state_q == ST_RUN) & ~man_pend_q; // R7 R8 R9
  wire protect_demand = (state_q == ST_DEMAND);
  wire rearm_request = (state_q == ST_INHIBIT) | (state_q == ST_ERROR);
  wire ready = (state_q != ST_IDLE);
  wire is_error = (state_q == ST_ERROR);
  wire is_probe = (state_q == ST_PROBE_LOW) | (state_q == ST_PROBE_HIGH);

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // APB slave: zero wait states, error on unmapped address
  wire apb_acc = i_psel & i_penable;
  wire addr_ok = (i_paddr == `TSM_CTRL_OFF) | (i_paddr == `TSM_STAT_OFF) |
                 (i_paddr == `TSM_DIAG_OFF) | (i_paddr == `TSM_WIN_OFF);
  wire ro_write = i_pwrite & (i_paddr != `TSM_CTRL_OFF);
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc & (~addr_ok | ro_write);
  assign o_prdata = rdata_q;

  // Control register write
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `TSM_CTRL_RST;
    end else if (apb_acc & i_pwrite & (i_paddr == `TSM_CTRL_OFF)) begin
      ctrl_q <= i_pwdata[`TSM_CTRL_W-1:0];
    end
  end

  // Read data captured in setup so it stands during the access phase
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      case (i_paddr)
        `TSM_CTRL_OFF: rdata_q <= {26'h0000000, ctrl_q};
        `TSM_STAT_OFF: rdata_q <= {23'h000000, man_pend_q, ~O_PROBE_DRIVE, is_error,
                                   rearm_request, protect_demand, passed_q,
                                   check_allowed, O_SAFE_SWITCH_OUT, ready};
        `TSM_DIAG_OFF: rdata_q <= {16'h0000, diag_q};
        `TSM_WIN_OFF: rdata_q <= {7'h00, WIN_CYC};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Next-state logic; disable is checked first so it overrides everything
  always @* begin
    state_d = state_q;
    diag_d = diag_q;
    if (!enable) begin
      state_d = ST_IDLE; // R13
      diag_d = `TSM_DG_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (WIN_BAD) begin
            state_d = ST_ERROR; // R2
            diag_d = `TSM_DG_ERR_WINDOW;
          end else if (!power_up_rearm) begin
            state_d = ST_INHIBIT;
            diag_d = `TSM_DG_INHIBIT;
          end else if (I_SENSOR_SWITCH_IN) begin
            state_d = ST_RUN;
            diag_d = `TSM_DG_RUN;
          end else begin
            state_d = ST_DEMAND;
            diag_d = `TSM_DG_DEMAND;
          end
        end
        ST_INHIBIT: begin
          if (I_SENSOR_SWITCH_IN & rearm_edge) begin
            state_d = ST_RUN; // R14
            diag_d = `TSM_DG_RUN;
          end
        end
        ST_RUN: begin
          if (!I_SENSOR_SWITCH_IN) begin
            state_d = ST_DEMAND; // R5 R6
            diag_d = `TSM_DG_DEMAND;
          end else if (begin_edge & check_allowed) begin
            state_d = ST_PROBE_LOW; // R1
            diag_d = `TSM_DG_PROBE_LOW;
          end
        end
        ST_DEMAND: begin
          if (I_SENSOR_SWITCH_IN) begin
            state_d = auto_rearm ? ST_RUN : ST_INHIBIT;
            diag_d = auto_rearm ? `TSM_DG_RUN : `TSM_DG_INHIBIT;
          end
        end
        ST_PROBE_LOW: begin
          if (!I_SENSOR_SWITCH_IN) begin
            state_d = ST_PROBE_HIGH; // R11
            diag_d = `TSM_DG_PROBE_HIGH;
          end else if (timeout) begin
            state_d = ST_ERROR; // R15
            diag_d = `TSM_DG_ERR_FALL;
          end
        end
        ST_PROBE_HIGH: begin
          if (I_SENSOR_SWITCH_IN) begin
            state_d = ST_RUN; // R11
            diag_d = `TSM_DG_RUN;
          end else if (timeout) begin
            state_d = ST_ERROR; // R15
            diag_d = `TSM_DG_ERR_RISE;
          end
        end
        ST_ERROR: begin
          // Window misconfiguration cannot be cleared by rearm
          if (!WIN_BAD & I_SENSOR_SWITCH_IN & rearm_edge) begin
            state_d = ST_RUN; // R12 R14
            diag_d = `TSM_DG_RUN;
          end
        end
        default: begin
          state_d = ST_IDLE;
          diag_d = `TSM_DG_IDLE;
        end
      endcase
    end
  end

  // State, diagnostic word and edge history
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      diag_q <= `TSM_DG_IDLE; // R16
      begin_prev_q <= 1'b0;
      rearm_prev_q <= 1'b0;
      sensor_prev_q <= 1'b1; // Sensor idles high, so no false rise after reset
    end else begin
      state_q <= state_d;
      diag_q <= diag_d;
      begin_prev_q <= ctrl_q[`TSM_CTRL_BEGIN];
      rearm_prev_q <= ctrl_q[`TSM_CTRL_REARM];
      sensor_prev_q <= I_SENSOR_SWITCH_IN;
    end
  end

  // Window counter runs across both probe phases; saturates to avoid wrap
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {`TSM_CNT_W{1'b0}};
    end else if (!is_probe) begin
      cnt_q <= {`TSM_CNT_W{1'b0}};
    end else if (!timeout) begin
      cnt_q <= cnt_q + {{(`TSM_CNT_W-1){1'b0}}, 1'b1}; // R15
    end
  end

  // Pass flag: rises only when the sensor answers inside the window
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      passed_q <= 1'b0; // R16
    end else if ((state_d == ST_PROBE_LOW) | (state_d == ST_ERROR) | !enable) begin
      passed_q <= 1'b0; // R10
    end else if ((state_q == ST_PROBE_HIGH) & (state_d == ST_RUN)) begin
      passed_q <= 1'b1; // R10
    end
  end

  // Manual switching sequence tracking: a full low-then-high of the sensor
  // outside a test releases the block after a failed test
  always @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      man_pend_q <= 1'b0;
      man_seen_low_q <= 1'b0;
    end else if (!enable) begin
      man_pend_q <= 1'b0;
      man_seen_low_q <= 1'b0;
    end else if (is_probe & (state_d == ST_ERROR)) begin
      man_pend_q <= ~skip_manual_recovery; // R7 R8
      man_seen_low_q <= 1'b0;
    end else if (man_pend_q & !is_probe) begin
      if (!I_SENSOR_SWITCH_IN) begin
        man_seen_low_q <= 1'b1;
      end else if (man_seen_low_q & sensor_rise) begin
        man_pend_q <= 1'b0; // R7
        man_seen_low_q <= 1'b0;
      end
    end
  end

  // Pin outputs decoded from the one-hot state, the pass flag and the manual pending flag
  assign O_PROBE_DRIVE = ~(state_q == ST_PROBE_LOW); // R3 R4
  assign O_SAFE_SWITCH_OUT = (state_q == ST_RUN) | is_probe; // R6 R11 R12
  assign O_CHECK_ALLOWED = check_allowed; // R9
  assign O_CHECK_PASSED = passed_q; // R10
  assign O_ERROR = is_error;

endmodule

// *** verif/tsm_sensor_monitor_assertions.sv ***
// Checker on the sensor monitor top ports
module tsm_sensor_monitor_chk #(
  parameter int CHECK_WINDOW_CYCLES = 20
) (
  input wire I_REF_CLK,
  input wire I_RESET_N,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire o_pready,
  input wire o_pslverr,
  input wire I_SENSOR_SWITCH_IN,
  input wire O_PROBE_DRIVE,
  input wire O_SAFE_SWITCH_OUT,
  input wire O_CHECK_ALLOWED,
  input wire O_CHECK_PASSED,
  input wire O_ERROR
);
  timeunit 1ns;
  timeprecision 1ns;
  // Both probe phases plus slack
  localparam int LIM = 2 * CHECK_WINDOW_CYCLES + 8;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RESET_N);
  // Control writes are the only way out of error
  wire ctrl_wr = i_psel && i_penable && i_pwrite && (i_paddr == 12'h000);
  sequence s_probe_go;
    $fell(O_PROBE_DRIVE);
  endsequence
  sequence s_probe_back;
    ##[1:LIM] O_PROBE_DRIVE;
  endsequence
  a_reset_outputs: assert property (disable iff (1'b0) !I_RESET_N |-> O_PROBE_DRIVE &&
    !O_SAFE_SWITCH_OUT && !O_CHECK_ALLOWED && !O_CHECK_PASSED && !O_ERROR)
    else $error("outputs wrong in reset");
  a_error_safe_low: assert property (O_ERROR |-> !O_SAFE_SWITCH_OUT)
    else $error("safe output high with error");
  a_safe_in_test: assert property (!O_PROBE_DRIVE |-> O_SAFE_SWITCH_OUT)
    else $error("safe output dropped during test");
  a_passed_low_test: assert property (!O_PROBE_DRIVE |-> !O_CHECK_PASSED)
    else $error("passed high while test runs");
  a_probe_window: assert property (s_probe_go |-> s_probe_back)
    else $error("probe low beyond window");
  a_error_held: assert property ($fell(O_ERROR) |-> $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("error cleared without control write");
  a_passed_rise: assert property ($rose(O_CHECK_PASSED) |->
    O_PROBE_DRIVE && I_SENSOR_SWITCH_IN && O_SAFE_SWITCH_OUT)
    else $error("passed rose without sensor return");
  a_unmapped_err: assert property (i_psel && i_penable && i_paddr > 12'h00C |->
    o_pready && o_pslverr)
    else $error("unmapped access not refused");
endmodule
bind tsm_sensor_monitor tsm_sensor_monitor_chk #(.CHECK_WINDOW_CYCLES(CHECK_WINDOW_CYCLES)) u_chk (
  .I_REF_CLK(I_REF_CLK), .I_RESET_N(I_RESET_N), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .I_SENSOR_SWITCH_IN(I_SENSOR_SWITCH_IN), .O_PROBE_DRIVE(O_PROBE_DRIVE),
  .O_SAFE_SWITCH_OUT(O_SAFE_SWITCH_OUT), .O_CHECK_ALLOWED(O_CHECK_ALLOWED),
  .O_CHECK_PASSED(O_CHECK_PASSED), .O_ERROR(O_ERROR));

// *** verif/tsm_sensor_model.sv ***
// Behavioural light sensor with test input
module tsm_sensor_model #(
  parameter int DELAY = 3
) (
  input wire logic i_clk,
  input wire logic i_probe,
  input wire logic [1:0] i_mode,
  output logic o_switch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DELAY-1:0] pipe_q = '1;
  // Mode 0 answers the probe late, 1 ignores it, 2 sees a broken beam
  always @(posedge i_clk) begin
    pipe_q <= {pipe_q[DELAY-2:0], i_probe};
    o_switch <= (i_mode == 2'd2) ? 1'b0 : (i_mode == 2'd1) ? 1'b1 : pipe_q[DELAY-1];
  end
endmodule

// *** verif/tb_testable_sensor_monitor.sv ***
// Bench for the sensor monitor over APB
module tb_testable_sensor_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  logic I_REF_CLK = 0, I_RESET_N = 1, psel = 0, pen = 0, pwr = 0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, rd, prdata;
  logic [1:0] mode = 2'd0;
  logic pready, perr, err, sw, probe, safe, allowed, passed, error;
  int fails = 0, tests_run = 0;
  always #4 I_REF_CLK = ~I_REF_CLK;
  tsm_sensor_monitor #(.CHECK_WINDOW_CYCLES(20)) dut (.I_REF_CLK(I_REF_CLK),
    .I_RESET_N(I_RESET_N), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
    .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
    .I_SENSOR_SWITCH_IN(sw), .O_PROBE_DRIVE(probe), .O_SAFE_SWITCH_OUT(safe),
    .O_CHECK_ALLOWED(allowed), .O_CHECK_PASSED(passed), .O_ERROR(error));
  tsm_sensor_model u_sensor (.i_clk(I_REF_CLK), .i_probe(probe), .i_mode(mode), .o_switch(sw));
  task complete_run();
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Setup cycle, then hold access until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge I_REF_CLK);
    psel <= 1; pwr <= w; pa <= a; pwd <= d;
    @(posedge I_REF_CLK);
    pen <= 1;
    n = 0;
    do begin
      @(posedge I_REF_CLK);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = perr;
    psel <= 0; pen <= 0;
    if (n == 50) begin
      fails++;
      $display("ERROR %0t bus answer timeout", $time);
      complete_run();
    end
  endtask
  function logic pick(int w);
    case (w) 0: return probe; 1: return passed; 2: return error; default: return allowed;
    endcase
  endfunction
  // Bounded wait, then let the edge settle
  task wt(input int w, input logic v);
    int n;
    n = 0;
    while (pick(w) !== v && n < 200) begin @(posedge I_REF_CLK); n++; end
    @(negedge I_REF_CLK);
    if (n == 200) begin
      fails++;
      $display("ERROR %0t wait timeout", $time);
      complete_run();
    end
  endtask
  // One failed test with the given skip bit, recovered by a rearm edge
  task fail_run(input logic [31:0] c);
    apb(1, 12'h000, c); mode <= 2'd1;
    apb(1, 12'h000, c | 32'h02); wt(2, 1);
    chk({probe, safe, passed}, 3'b100);
    apb(0, 12'h008, 0); chk(rd, 32'hC001);
    apb(1, 12'h000, c); mode <= 2'd0; repeat (6) @(posedge I_REF_CLK);
    chk(error, 1);
    apb(1, 12'h000, c | 32'h20); wt(2, 0);
  endtask
  initial begin
    // A real falling edge, so the async reset loads every flop before the first clock
    I_RESET_N <= 0;
    repeat (8) @(posedge I_REF_CLK);
    I_RESET_N <= 1;
    repeat (3) @(posedge I_REF_CLK);
    @(negedge I_REF_CLK);
    chk({probe, safe, allowed, passed, error}, 5'b10000);
    apb(0, 12'h008, 0); chk(rd, 0);
    apb(1, 12'h000, 32'h19); wt(3, 1); chk(safe, 1);
    apb(1, 12'h000, 32'h1B); wt(0, 0); chk(safe, 1);
    wt(1, 1); chk({probe, passed}, 2'b11);
    apb(0, 12'h008, 0); chk(rd, 32'h8000);
    fail_run(32'h19); chk(allowed, 0);
    mode <= 2'd2; repeat (6) @(posedge I_REF_CLK); mode <= 2'd0;
    wt(3, 1);
    fail_run(32'h1D); wt(3, 1); chk(allowed, 1);
    // Sensor falls but never returns: the rise phase runs out
    apb(1, 12'h000, 32'h1D);
    apb(1, 12'h000, 32'h1F);
    wt(0, 0);
    @(posedge I_REF_CLK);
    mode <= 2'd2;
    wt(2, 1);
    chk({probe, safe, passed}, 3'b100);
    apb(0, 12'h008, 0);
    chk(rd, 32'hC002);
    apb(1, 12'h000, 32'h1D);
    mode <= 2'd0;
    apb(1, 12'h000, 32'h3D);
    wt(2, 0);
    apb(0, 12'h004, 0);
    chk(rd, 32'h7);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h14);
    apb(0, 12'h000, 0);
    chk(rd, 32'h3D);
    apb(0, 12'h010, 0); chk({err, rd}, {1'b1, 32'h0});
    apb(1, 12'h004, 32'hFF); chk(err, 1);
    apb(1, 12'h000, 32'h0); repeat (2) @(negedge I_REF_CLK);
    chk({safe, allowed, error}, 3'b000);
    // Startup inhibit, then a demand with auto rearm off
    apb(1, 12'h000, 32'h01);
    apb(0, 12'h004, 0);
    chk(rd, 32'h21);
    apb(1, 12'h000, 32'h21);
    wt(3, 1);
    chk(safe, 1);
    @(posedge I_REF_CLK);
    mode <= 2'd2;
    wt(3, 0);
    apb(0, 12'h004, 0);
    chk(rd, 32'h11);
    mode <= 2'd0;
    repeat (3) @(posedge I_REF_CLK);
    apb(0, 12'h008, 0);
    chk(rd, 32'h8001);
    complete_run();
  end
endmodule
